/* rtl/isx_map.vh */
/*
 * Address map, status word layout, reset values and cycle figures of the
 * instruction execution unit. Holds definitions only; included by the unit.
 */
`ifndef ISX_MAP_VH
`define ISX_MAP_VH

`define ISX_OFF_INSN       6'h00
`define ISX_OFF_EXT        6'h04
`define ISX_OFF_CTRL       6'h08
`define ISX_OFF_PC         6'h0c
`define ISX_OFF_PSW        6'h10
`define ISX_OFF_GSEL       6'h14
`define ISX_OFF_GDATA      6'h18
`define ISX_OFF_MSEL       6'h1c
`define ISX_OFF_MDATA      6'h20

`define ISX_CTRL_GO        0
`define ISX_CTRL_BUSY      0
`define ISX_CTRL_ILL       1
`define ISX_CTRL_PSWW      2

`define ISX_PSW_Z          0
`define ISX_PSW_S          1
`define ISX_PSW_OV         2
`define ISX_PSW_CY         3
`define ISX_PSW_SAT        4
`define ISX_INTERRUPT_DISABLE_BIT         5
`define ISX_EXCEPTION_PENDING_BIT         6
`define ISX_NMI_PENDING_BIT         7

`define ISX_PSW_RST        8'h20
`define ISX_PC_RST         32'h00000000
`define ISX_TRAP_LO        32'h00000040
`define ISX_TRAP_HI        32'h00000050
`define ISX_TRAP_CODE      16'h0040

`define ISX_SR_INTERRUPT_SAVED_PC        5'h00
`define ISX_SR_INTERRUPT_SAVED_STATUS       5'h01
`define ISX_SR_FATAL_SAVED_PC        5'h02
`define ISX_SR_FATAL_SAVED_STATUS       5'h03
`define ISX_SR_ECR         5'h04
`define ISX_SR_PSW         5'h05

`define ISX_GR_SP          5'h03
`define ISX_GR_EP          5'h1e
`define ISX_GR_LIST        5'h14

`define ISX_CYC_BIT        8'h03
`define ISX_CYC_RET        8'h03
`define ISX_CYC_TRAP       8'h03
`define ISX_CYC_SWITCH     8'h05
`define ISX_CYC_BR         8'h02
`define ISX_CYC_BR_PSW     8'h03
`define ISX_LAT_SHORT      8'h01
`define ISX_LAT_DISP       8'h02

`endif

/* rtl/isx_exec_unit.v */
/*
 * Execution unit for the logic, shift, saturating, conditional-set, frame
 * setup, exception return, table jump, trap, bit, load/store, extend and
 * system register transfer instructions. Software loads an instruction,
 * starts it and watches busy over Avalon-MM. Assumes one clock and a master
 * that holds each request until waitrequest is seen low.
 */
`timescale 1ns/1ps
`include "isx_map.vh"

// Functional notes
// - Frame setup pushes each masked register below stack pointer, then subtracts imm5.
// - Frame setup field ff picks element pointer: sp, sext16, imm16 shifted, imm32.
// - Frame setup loading element pointer takes n+2 cycles, n+3 with imm32.
// - n counts mask registers scaled by wait states; empty mask counts as one.
// - Exception return restores pc and status from the pending-bit selected pair.
// - Shifts by register or imm5 update carry, sign, zero and clear overflow.
// - Shift-and-set-flag shifts left one and ORs in the condition result.
// - Set-on-condition writes one or zero, flags untouched, one cycle.
// - Bit set, clear, invert load Z from inverted bit then write bit back.
// - Bit test only sets Z from the inverted memory bit.
// - Memory bit instructions take three cycles plus read wait states.
// - Table jump loads halfword at PC+2 plus index times two, then branches.
// - Trap saves PC+4 and status, sets code, pending, disable; vectors 40H/50H.
// - Extends replace register with sign or zero extended low byte or half.
// - Logic ops zero-extend imm16, clear overflow, set sign and zero.
// - Short element-pointer loads deliver after one cycle plus wait states.
// - Sixteen-bit displacement loads deliver after two cycles plus wait states.
// - Taken branch takes three cycles after an instruction that changed the status value.
// - Load system register takes register number from upper field, source lower.
// - Halfword and word disp16 encodings hold only the upper fifteen bits.
// - Short halfword forms hold upper seven bits, word forms upper six bits.
// - Short unsigned loads need a nonzero destination; halfword disp is upper four.
// - Four-bit condition codes are evaluated from the status flags.
module isx_exec_unit #(
	parameter MEM_AW = 6
) (
	// Clock and reset
	input  wire        sys_clk,
	input  wire        reset,
	// Avalon-MM slave
	input  wire [3:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	input  wire [3:0]  avs_byteenable,
	output reg  [31:0] avs_readdata,
	output reg         avs_waitrequest
);
	localparam ST_IDLE = 2'd0;
	localparam ST_WAIT = 2'd1;
	localparam ST_PUSH = 2'd2;

	reg [31:0] gpr [0:31];
	reg [31:0] mem [0:(1<<MEM_AW)-1];
	reg [31:0] insn_r, ext_r, pc_r, interrupt_saved_pc_r, interrupt_saved_status_r, fatal_saved_pc_r, fatal_saved_status_r, ecr_r;
	reg [7:0]  psw_r, cyc_r, tgt_r;
	reg [3:0]  wait_r;
	reg [4:0]  gsel_r;
	reg [MEM_AW-1:0] msel_r;
	reg [1:0]  state_r;
	reg [11:0] mask_r;
	reg        illegal_r, pswWrote_r;
	integer    k;

	function condOk(input [3:0] c, input [7:0] p);
		reg r;
		begin
			case (c[2:0])
				3'h0: r = p[`ISX_PSW_OV];
				3'h1: r = p[`ISX_PSW_CY];
				3'h2: r = p[`ISX_PSW_Z];
				3'h3: r = p[`ISX_PSW_CY] | p[`ISX_PSW_Z];
				3'h4: r = p[`ISX_PSW_S];
				3'h5: r = c[3] ? ~p[`ISX_PSW_SAT] : 1'b1;
				3'h6: r = p[`ISX_PSW_S] ^ p[`ISX_PSW_OV];
				default: r = (p[`ISX_PSW_S] ^ p[`ISX_PSW_OV]) | p[`ISX_PSW_Z];
			endcase
			condOk = r ^ c[3];
		end
	endfunction

	function [7:0] flg(input [7:0] p, input [31:0] r, input cy, input ov, input upCy);
		begin
			flg = p;
			flg[`ISX_PSW_Z] = (r == 32'h0);
			flg[`ISX_PSW_S] = r[31];
			flg[`ISX_PSW_OV] = ov;
			if (upCy) begin
				flg[`ISX_PSW_CY] = cy;
			end
		end
	endfunction

	function [31:0] ldx(input [31:0] w, input [1:0] a, input [1:0] sz, input uns);
		reg [31:0] b, h;
		begin
			b = w >> {a, 3'b000};
			h = w >> {a[1], 4'h0};
			case (sz)
				2'd0: ldx = {{24{b[7] & ~uns}}, b[7:0]};
				2'd1: ldx = {{16{h[15] & ~uns}}, h[15:0]};
				default: ldx = w;
			endcase
		end
	endfunction

	function [3:0] stBe(input [1:0] a, input [1:0] sz);
		begin
			stBe = (sz == 2'd0) ? (4'h1 << a) : (sz == 2'd1) ? (a[1] ? 4'hc : 4'h3) : 4'hf;
		end
	endfunction

	function [31:0] merge(input [31:0] o, input [31:0] n, input [3:0] be);
		integer i;
		begin
			for (i = 0; i < 4; i = i + 1) begin
				merge[i*8 +: 8] = be[i] ? n[i*8 +: 8] : o[i*8 +: 8];
			end
		end
	endfunction

	function [3:0] hiBit(input [11:0] m);
		integer i;
		begin
			hiBit = 4'h0;
			for (i = 0; i < 12; i = i + 1) begin
				if (m[i]) begin
					hiBit = i[3:0];
				end
			end
		end
	endfunction

	function [3:0] popc(input [11:0] m);
		integer i;
		begin
			popc = 4'h0;
			for (i = 0; i < 12; i = i + 1) begin
				popc = popc + {3'h0, m[i]};
			end
		end
	endfunction

	// Instruction fields and operands.
	wire [15:0] hw0   = insn_r[15:0];
	wire [15:0] hw1   = insn_r[31:16];
	wire [4:0]  r1    = hw0[4:0];
	wire [4:0]  r2    = hw0[15:11];
	wire [5:0]  op    = hw0[10:5];
	wire [31:0] gA    = gpr[r1];
	wire [31:0] gB    = gpr[r2];
	wire [31:0] sp    = gpr[`ISX_GR_SP];
	wire [31:0] sx5   = {{27{r1[4]}}, r1};
	wire [31:0] sx16  = {{16{hw1[15]}}, hw1};
	wire [31:0] dsp16 = {{16{hw1[15]}}, hw1[15:1], 1'b0};
	wire        isExt = (op == 6'h3f) && !hw1[0];
	wire [11:0] lst   = {hw1[15:5], hw0[0]};
	wire [1:0]  ff    = hw1[4:3];
	wire [31:0] len   = (hw0[10:9] == 2'b11) ? 32'h4 : 32'h2;

	// Shifter; the extra bit catches the last bit shifted out as carry.
	wire [4:0]  amt  = isExt ? gA[4:0] : r1;
	wire [32:0] shrT = {gB, 1'b0} >> amt;
	wire [32:0] sarT = $signed({gB, 1'b0}) >>> amt;
	wire [32:0] shlT = {1'b0, gB} << amt;

	// Saturating adder shared by the add, subtract and reverse subtract forms.
	wire        satRev = (op == 6'h04) || (op == 6'h33);
	wire        satSub = (op != 6'h06) && (op != 6'h11);
	wire [31:0] satX   = satRev ? gA : gB;
	wire [31:0] satY   = (op == 6'h04) ? gB : (op == 6'h11) ? sx5 : (op == 6'h33) ? sx16 : gA;
	wire [32:0] satRaw = satSub ? ({1'b0, satX} - {1'b0, satY}) : ({1'b0, satX} + {1'b0, satY});
	wire        satOv  = (satX[31] ^ satRaw[31]) & (satSub ^ ~(satX[31] ^ satY[31]));
	wire [31:0] satRes = satOv ? (satX[31] ? 32'h80000000 : 32'h7fffffff) : satRaw[31:0];

	// Bus side.
	wire        req   = avs_read | avs_write;
	wire        wrAcc = avs_write & ~avs_waitrequest;
	wire [5:0]  wOff  = {avs_address, 2'b00};
	wire        idle  = (state_r == ST_IDLE);
	reg  [31:0] rdMux;
	wire [31:0] avWd  = merge(rdMux, avs_writedata, avs_byteenable);
	wire [3:0]  ws    = avWd[7:4];
	wire        start = wrAcc & idle & (wOff == `ISX_OFF_CTRL) & avWd[`ISX_CTRL_GO];
	wire [3:0]  cnt   = popc(lst);
	wire [7:0]  nPrep = ((cnt == 4'h0) ? 8'h01 : {4'h0, cnt}) * ({4'h0, ws} + 8'h01);

	always @* begin
		case (wOff)
			`ISX_OFF_INSN:  rdMux = insn_r;
			`ISX_OFF_EXT:   rdMux = ext_r;
			`ISX_OFF_CTRL:  rdMux = {16'h0, tgt_r, wait_r, 1'b0, pswWrote_r, illegal_r, ~idle};
			`ISX_OFF_PC:    rdMux = pc_r;
			`ISX_OFF_PSW:   rdMux = {24'h0, psw_r};
			`ISX_OFF_GSEL:  rdMux = {27'h0, gsel_r};
			`ISX_OFF_GDATA: rdMux = gpr[gsel_r];
			`ISX_OFF_MSEL:  rdMux = {{(32-MEM_AW){1'b0}}, msel_r};
			`ISX_OFF_MDATA: rdMux = mem[msel_r];
			default:        rdMux = 32'h0;
		endcase
	end

	reg        xGWe, xMWe, xTrap, xSrWe, xIll, xPrep, doSh, doLog, doSat, doLd, doSt, uns;
	reg [4:0]  xGIdx;
	reg [31:0] xGVal, xPc, xAdr, xMVal, mw, t, lres;
	reg [7:0]  xPsw, xCyc, tb, nb, lat;
	reg [3:0]  xBe;
	reg [2:0]  bitN;
	reg [1:0]  sk, sz;

	always @* begin
		xGWe = 1'b0; xMWe = 1'b0; xTrap = 1'b0; xSrWe = 1'b0; xIll = 1'b0; xPrep = 1'b0;
		doSh = 1'b0; doLog = 1'b0; doSat = 1'b0; doLd = 1'b0; doSt = 1'b0; uns = 1'b0;
		xGIdx = r2; xGVal = 32'h0; xPc = pc_r + len; xMVal = 32'h0; t = 32'h0; lres = 32'h0;
		xPsw = psw_r; xCyc = 8'h01; lat = `ISX_LAT_DISP; xBe = 4'h0; sk = 2'd0; sz = 2'd2;
		// Operand address; short forms are element-pointer relative.
		casez (op)
			6'b011???: xAdr = gpr[`ISX_GR_EP] + {25'h0, hw0[6:0]};
			6'b100???: xAdr = gpr[`ISX_GR_EP] + {24'h0, hw0[6:0], 1'b0};
			6'b1010??: xAdr = gpr[`ISX_GR_EP] + {24'h0, hw0[6:1], 2'b00};
			6'b000011: xAdr = gpr[`ISX_GR_EP] + (hw0[4] ? {27'h0, hw0[3:0], 1'b0} : {28'h0, hw0[3:0]});
			6'b000010: xAdr = pc_r + 32'h2 + {gA[30:0], 1'b0};
			6'b111000, 6'b111010, 6'b111110: xAdr = isExt ? gA : gA + sx16;
			6'b11110?: xAdr = gA + {{16{hw1[15]}}, hw1[15:1], hw0[5]};
			default:   xAdr = isExt ? gA : gA + dsp16;
		endcase
		mw = mem[xAdr[MEM_AW+1:2]];
		t = mw >> {xAdr[1:0], 3'b000};
		tb = t[7:0];
		bitN = isExt ? gB[2:0] : hw0[13:11];
		nb = tb;
		if (isExt || op == 6'h3e) begin
			if (!isExt || hw1[15:3] == 13'h001c) begin
				// Bit kind: 0 set, 1 invert, 2 clear, 3 test.
				sk = isExt ? hw1[2:1] : hw0[15:14];
				nb[bitN] = (sk == 2'd0) | ((sk == 2'd1) & ~tb[bitN]);
				xPsw[`ISX_PSW_Z] = ~tb[bitN];
				xMWe = (sk != 2'd3);
				xBe = 4'h1 << xAdr[1:0];
				xMVal = {4{nb}};
				xCyc = `ISX_CYC_BIT + {4'h0, ws};
			end else begin
				case (hw1)
					16'h0080, 16'h00a0, 16'h00c0: begin
						doSh = 1'b1;
						sk = hw1[6:5];
					end
					16'h0020: begin
						// Register number sits in the upper field, source below.
						if (r2 == `ISX_SR_PSW) begin
							xPsw = gA[7:0];
						end else begin
							xSrWe = 1'b1;
						end
					end
					16'h0040: begin
						xGWe = 1'b1;
						case (r1)
							`ISX_SR_INTERRUPT_SAVED_PC:  xGVal = interrupt_saved_pc_r;
							`ISX_SR_INTERRUPT_SAVED_STATUS: xGVal = interrupt_saved_status_r;
							`ISX_SR_FATAL_SAVED_PC:  xGVal = fatal_saved_pc_r;
							`ISX_SR_FATAL_SAVED_STATUS: xGVal = fatal_saved_status_r;
							`ISX_SR_ECR:   xGVal = ecr_r;
							`ISX_SR_PSW:   xGVal = {24'h0, psw_r};
							default:       xGVal = 32'h0;
						endcase
					end
					16'h0000: begin
						xGWe = 1'b1;
						xGVal = {31'h0, condOk(hw0[3:0], psw_r)};
						xIll = hw0[4];
					end
					16'h0200: begin
						xGWe = 1'b1;
						xGVal = {gB[30:0], condOk(hw0[3:0], psw_r)};
						xIll = hw0[4];
					end
					16'h0140: begin
						xIll = (hw0 != 16'h07e0);
						xCyc = `ISX_CYC_RET;
						// Interrupt pair wins while an exception is pending.
						if (!psw_r[`ISX_EXCEPTION_PENDING_BIT] && psw_r[`ISX_NMI_PENDING_BIT]) begin
							xPc = fatal_saved_pc_r;
							xPsw = fatal_saved_status_r[7:0];
						end else begin
							xPc = interrupt_saved_pc_r;
							xPsw = interrupt_saved_status_r[7:0];
						end
					end
					16'h0100: begin
						xIll = (r2 != 5'h0);
						xTrap = 1'b1;
						xCyc = `ISX_CYC_TRAP;
						xPsw[`ISX_EXCEPTION_PENDING_BIT] = 1'b1;
						xPsw[`ISX_INTERRUPT_DISABLE_BIT] = 1'b1;
						xPc = r1[4] ? `ISX_TRAP_HI : `ISX_TRAP_LO;
					end
					default: xIll = 1'b1;
				endcase
			end
		end else if (hw0[10:6] == 5'h1e && r2 == 5'h0 && hw1[0] && !hw1[2]) begin
			xPrep = 1'b1;
			xCyc = nPrep + ((hw1[1] == 1'b0) ? 8'h01 : (ff == 2'b11) ? 8'h03 : 8'h02);
			xPc = pc_r + 32'h4 + ((hw1[1] == 1'b0 || ff == 2'b00) ? 32'h0 :
				(ff == 2'b11) ? 32'h4 : 32'h2);
		end else begin
			casez (op)
				6'b001000, 6'b001001, 6'b001011, 6'b110100, 6'b110101: begin
					doLog = 1'b1;
					xGWe = (op != 6'h0b);
				end
				6'b000100, 6'b000101, 6'b000110, 6'b000111: begin
					if (r2 == 5'h0) begin
						xGWe = 1'b1;
						xGIdx = r1;
						xGVal = op[1] ? {{16{gA[15] & op[0]}}, gA[15:0]} :
							{{24{gA[7] & op[0]}}, gA[7:0]};
					end else begin
						doSat = ~op[0] | ~op[1];
						xIll = op[0] & op[1];
					end
				end
				6'b010001, 6'b110011: doSat = 1'b1;
				6'b010100, 6'b010101, 6'b010110: begin
					doSh = 1'b1;
					sk = op[1:0];
				end
				6'b000010: begin
					xIll = (r2 != 5'h0);
					xCyc = `ISX_CYC_SWITCH;
					t = ldx(mw, xAdr[1:0], 2'd1, 1'b0);
					xPc = pc_r + 32'h2 + {t[30:0], 1'b0};
				end
				6'b000011: begin
					xIll = (r2 == 5'h0);
					doLd = ~xIll;
					uns = 1'b1;
					sz = {1'b0, hw0[4]};
					lat = `ISX_LAT_SHORT;
				end
				6'b0110??, 6'b1000??: begin
					doLd = 1'b1;
					sz = {1'b0, op[5]};
					lat = `ISX_LAT_SHORT;
				end
				6'b0111??, 6'b1001??: begin
					doSt = 1'b1;
					sz = {1'b0, op[5]};
				end
				6'b1010??: begin
					doLd = ~hw0[0];
					doSt = hw0[0];
					lat = `ISX_LAT_SHORT;
				end
				6'b1011??: begin
					if (condOk(hw0[3:0], psw_r)) begin
						xPc = pc_r + {{23{hw0[15]}}, hw0[15:11], hw0[6:4], 1'b0};
						xCyc = pswWrote_r ? `ISX_CYC_BR_PSW : `ISX_CYC_BR;
					end
				end
				6'b111000, 6'b111001: begin
					doLd = 1'b1;
					sz = op[0] ? (hw1[0] ? 2'd2 : 2'd1) : 2'd0;
				end
				6'b111010, 6'b111011: begin
					doSt = 1'b1;
					sz = op[0] ? (hw1[0] ? 2'd2 : 2'd1) : 2'd0;
				end
				6'b11110?, 6'b111111: begin
					xIll = (r2 == 5'h0);
					doLd = ~xIll;
					uns = 1'b1;
					sz = {1'b0, op[1]};
				end
				default: xIll = 1'b1;
			endcase
		end
		if (doSh) begin
			xGWe = 1'b1;
			xGVal = (sk == 2'd2) ? shlT[31:0] : (sk == 2'd1) ? sarT[32:1] : shrT[32:1];
			xPsw = flg(psw_r, xGVal, (sk == 2'd2) ? shlT[32] : (sk == 2'd1) ? sarT[0] : shrT[0],
				1'b0, 1'b1);
		end
		if (doLog) begin
			// Immediates are zero-extended; carry is left alone.
			case (op)
				6'h08:   lres = gB | gA;
				6'h09:   lres = gB ^ gA;
				6'h34:   lres = gA | {16'h0, hw1};
				6'h35:   lres = gA ^ {16'h0, hw1};
				default: lres = gB & gA;
			endcase
			xGVal = lres;
			xPsw = flg(psw_r, lres, 1'b0, 1'b0, 1'b0);
		end
		if (doSat) begin
			xGWe = 1'b1;
			xGVal = satRes;
			xPsw = flg(psw_r, satRes, satRaw[32], satOv, 1'b1);
			xPsw[`ISX_PSW_SAT] = psw_r[`ISX_PSW_SAT] | satOv;
		end
		if (doLd) begin
			// Result stands at once; busy covers the documented latency.
			xGWe = 1'b1;
			xGVal = ldx(mw, xAdr[1:0], sz, uns);
			xCyc = lat + {4'h0, ws};
		end
		if (doSt) begin
			xMWe = 1'b1;
			xBe = stBe(xAdr[1:0], sz);
			xMVal = (sz == 2'd0) ? {4{gB[7:0]}} : (sz == 2'd1) ? {2{gB[15:0]}} : gB;
		end
		if (xIll) begin
			xGWe = 1'b0;
			xMWe = 1'b0;
			xSrWe = 1'b0;
			xTrap = 1'b0;
			xPsw = psw_r;
		end
	end

	// Frame setup push step: highest listed register goes first.
	wire        pushing = (state_r == ST_PUSH) && (mask_r != 12'h0);
	wire        prepEnd = (state_r == ST_PUSH) && (mask_r == 12'h0);
	wire [3:0]  pk      = hiBit(mask_r);
	wire [31:0] pushAdr = sp - 32'h4;
	wire [31:0] epLoad  = (ff == 2'b00) ? sp - {27'h0, hw0[5:1]} : (ff == 2'b01) ?
		{{16{ext_r[15]}}, ext_r[15:0]} : (ff == 2'b10) ? {ext_r[15:0], 16'h0} : ext_r;

	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			for (k = 0; k < 32; k = k + 1) begin
				gpr[k] <= 32'h0;
			end
		end else if (start && xGWe && xGIdx != 5'h0) begin
			gpr[xGIdx] <= xGVal;
		end else if (pushing) begin
			gpr[`ISX_GR_SP] <= pushAdr;
		end else if (prepEnd) begin
			gpr[`ISX_GR_SP] <= sp - {27'h0, hw0[5:1]};
			if (hw1[1]) begin
				gpr[`ISX_GR_EP] <= epLoad;
			end
		end else if (wrAcc && idle && wOff == `ISX_OFF_GDATA && gsel_r != 5'h0) begin
			gpr[gsel_r] <= avWd;
		end
	end

	always @(posedge sys_clk) begin
		if (start && xMWe) begin
			mem[xAdr[MEM_AW+1:2]] <= merge(mw, xMVal, xBe);
		end else if (pushing) begin
			mem[pushAdr[MEM_AW+1:2]] <= gpr[`ISX_GR_LIST + {1'b0, pk}];
		end else if (wrAcc && idle && wOff == `ISX_OFF_MDATA) begin
			mem[msel_r] <= avWd;
		end
	end

	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0;
			insn_r <= 32'h0; ext_r <= 32'h0; pc_r <= `ISX_PC_RST; psw_r <= `ISX_PSW_RST;
			interrupt_saved_pc_r <= 32'h0; interrupt_saved_status_r <= 32'h0; fatal_saved_pc_r <= 32'h0; fatal_saved_status_r <= 32'h0;
			ecr_r <= 32'h0; wait_r <= 4'h0; gsel_r <= 5'h0; msel_r <= {MEM_AW{1'b0}};
			state_r <= ST_IDLE; cyc_r <= 8'h0; tgt_r <= 8'h0; mask_r <= 12'h0;
			illegal_r <= 1'b0; pswWrote_r <= 1'b0;
		end else begin
			// One wait cycle, then a single-cycle acknowledge.
			avs_waitrequest <= ~(req & avs_waitrequest);
			if (avs_read && avs_waitrequest) begin
				avs_readdata <= rdMux;
			end
			if (wrAcc && wOff == `ISX_OFF_GSEL) begin
				gsel_r <= avWd[4:0];
			end
			if (wrAcc && wOff == `ISX_OFF_MSEL) begin
				msel_r <= avWd[MEM_AW-1:0];
			end
			// Engine state may not be changed under a running instruction.
			if (wrAcc && idle) begin
				case (wOff)
					`ISX_OFF_INSN: insn_r <= avWd;
					`ISX_OFF_EXT:  ext_r <= avWd;
					`ISX_OFF_CTRL: wait_r <= avWd[7:4];
					`ISX_OFF_PC:   pc_r <= avWd;
					`ISX_OFF_PSW:  psw_r <= avWd[7:0];
					default: ;
				endcase
			end
			if (start) begin
				pc_r <= xPc;
				psw_r <= xPsw;
				pswWrote_r <= (xPsw != psw_r);
				illegal_r <= xIll;
				tgt_r <= xCyc;
				cyc_r <= 8'h01;
				mask_r <= lst;
				state_r <= xPrep ? ST_PUSH : ST_WAIT;
				if (xTrap) begin
					interrupt_saved_pc_r <= pc_r + 32'h4;
					interrupt_saved_status_r <= {24'h0, psw_r};
					ecr_r[15:0] <= `ISX_TRAP_CODE + {11'h0, r1};
				end
				if (xSrWe) begin
					case (r2)
						`ISX_SR_INTERRUPT_SAVED_PC:  interrupt_saved_pc_r <= gA;
						`ISX_SR_INTERRUPT_SAVED_STATUS: interrupt_saved_status_r <= gA;
						`ISX_SR_FATAL_SAVED_PC:  fatal_saved_pc_r <= gA;
						`ISX_SR_FATAL_SAVED_STATUS: fatal_saved_status_r <= gA;
						default: ;
					endcase
				end
			end else begin
				case (state_r)
					ST_PUSH: begin
						cyc_r <= cyc_r + 8'h01;
						if (pushing) begin
							mask_r[pk] <= 1'b0;
						end else begin
							state_r <= (cyc_r >= tgt_r) ? ST_IDLE : ST_WAIT;
						end
					end
					ST_WAIT: begin
						if (cyc_r >= tgt_r) begin
							state_r <= ST_IDLE;
						end else begin
							cyc_r <= cyc_r + 8'h01;
						end
					end
					default: state_r <= ST_IDLE;
				endcase
			end
		end
	end
endmodule

/* testbench/isx_avm_master.sv */
/*
 * Avalon-MM master model that stands on the far side of the execution unit.
 * Assumes one clock; every request waits for waitrequest low, bounded.
 */
`timescale 1ns/1ps
module isx_avm_master (
	// Clock
	input wire		sys_clk,
	// Avalon-MM master
	output logic [3:0]	avs_address,
	output logic		avs_read,
	output logic		avs_write,
	output logic [31:0]	avs_writedata,
	output logic [3:0]	avs_byteenable,
	input wire [31:0]	avs_readdata,
	input wire		avs_waitrequest
);
	initial begin
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hf;
	end
	// One idle edge before each request keeps release and raise in separate steps.
	task xfer(input logic rd, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic tmo);
		int n;
		begin
			n = 0;
			@(posedge sys_clk);
			avs_address <= a;
			avs_read <= rd;
			avs_write <= !rd;
			avs_writedata <= d;
			do begin
				@(posedge sys_clk);
				n++;
			end while (avs_waitrequest && n < 50);
			q = avs_readdata;
			tmo = avs_waitrequest;
			avs_read <= 1'b0;
			avs_write <= 1'b0;
		end
	endtask
endmodule

/* testbench/isx_exec_unit_properties.sv */
/*
 * Checker for the execution unit's Avalon-MM port.
 * Sees only the unit's ports; bound to every instance of the unit.
 */
`timescale 1ns/1ps
module isx_exec_unit_properties (
	// Clock and reset
	input wire		sys_clk,
	input wire		reset,
	// Avalon-MM slave
	input wire [3:0]	avs_address,
	input wire		avs_read,
	input wire		avs_write,
	input wire [31:0]	avs_writedata,
	input wire [3:0]	avs_byteenable,
	input wire [31:0]	avs_readdata,
	input wire		avs_waitrequest
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	wire		req = avs_read | avs_write;
	logic [4:0]	gsel_r;
	always @(posedge sys_clk or posedge reset) begin
		if (reset)
			gsel_r <= 5'h0;
		else if (avs_write && !avs_waitrequest && avs_address == 4'h5)
			gsel_r <= avs_writedata[4:0];
	end
	sequence reqSeen;
		req && avs_waitrequest;
	endsequence
	sequence ackSeen;
		!avs_waitrequest;
	endsequence
	sequence rdAck;
		avs_read && !avs_waitrequest;
	endsequence
	first_wait_a: assert property ($fell(reset) |-> avs_waitrequest) else $error("ack in reset");
	ack_next_a: assert property (reqSeen |=> ackSeen) else $error("late ack");
	ack_pulse_a: assert property (ackSeen |=> avs_waitrequest) else $error("long ack");
	idle_wait_a: assert property (!req && avs_waitrequest |=> avs_waitrequest) else $error("stray ack");
	rdata_hold_a: assert property ($changed(avs_readdata) |-> rdAck) else $error("data moved");
	unmapped_zero_a: assert property (rdAck and avs_address > 4'h8 |-> avs_readdata == 32'h0)
		else $error("unmapped data");
	psw_bits_a: assert property (rdAck and avs_address == 4'h4 |-> avs_readdata[31:8] == 24'h0)
		else $error("psw spare bits");
	zero_reg_a: assert property (rdAck and avs_address == 4'h6 && gsel_r == 5'h0
		|-> avs_readdata == 32'h0) else $error("r0 not zero");
endmodule
bind isx_exec_unit isx_exec_unit_properties isx_exec_unit_properties_inst (
	.sys_clk(sys_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

/* testbench/isx_exec_unit_tb.sv */
/*
 * Self-checking bench: loads instructions over Avalon-MM and compares
 * registers, memory, status and cycle counts. Assumes the master model.
 */
`timescale 1ns/1ps
module isx_exec_unit_tb;
	logic		sysClk;
	logic		reset;
	wire [3:0]	avsAddress;
	wire		avsRead;
	wire		avsWrite;
	wire [31:0]	avsWritedata;
	wire [3:0]	avsByteenable;
	wire [31:0]	avsReaddata;
	wire		avsWaitrequest;
	int		errTotal;
	int		checked;
	logic [31:0]	q;
	logic [31:0]	program_status_word;
	logic [15:0]	bitOp [4] = '{16'h17c6, 16'hd7c6, 16'h57c6, 16'h97c6};
	logic [3:0]	bitExp [4] = '{4'h5, 4'h4, 4'h0, 4'h1};
	logic [31:0]	extExp [4] = '{32'hf0, 32'hfffffff0, 32'h80f0, 32'hffff80f0};
	isx_exec_unit isx_exec_unit_inst (.sys_clk(sysClk), .reset(reset),
		.avs_address(avsAddress), .avs_read(avsRead), .avs_write(avsWrite),
		.avs_writedata(avsWritedata), .avs_byteenable(avsByteenable),
		.avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest));
	isx_avm_master isx_avm_master_inst (.sys_clk(sysClk), .avs_address(avsAddress),
		.avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWritedata),
		.avs_byteenable(avsByteenable), .avs_readdata(avsReaddata),
		.avs_waitrequest(avsWaitrequest));
	initial begin
		sysClk = 1'b0;
		forever #50 sysClk = ~sysClk;
	end
	task endOfTest;
		$display("checks %0d mismatches %0d", checked, errTotal);
		if (errTotal == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			errTotal++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask
	task bus(input logic rd, input logic [3:0] a, input logic [31:0] d);
		logic tmo;
		isx_avm_master_inst.xfer(rd, a, d, q, tmo);
		if (tmo !== 1'b0) begin
			errTotal++;
			endOfTest;
		end
	endtask
	task gset(input logic [4:0] r, input logic [31:0] v);
		bus(1'b0, 4'h5, {27'h0, r});
		bus(1'b0, 4'h6, v);
	endtask
	task gchk(input logic [4:0] r, input logic [31:0] e);
		bus(1'b0, 4'h5, {27'h0, r});
		bus(1'b1, 4'h6, 32'h0);
		chk("gpr", e, q);
	endtask
	// Starts one instruction, polls busy, then checks the count and reads status.
	task run(input logic [31:0] i, input logic [31:0] x, input logic [3:0] ws,
		input logic [7:0] cyc);
		int n;
		bus(1'b0, 4'h0, i);
		bus(1'b0, 4'h1, x);
		bus(1'b0, 4'h2, {24'h0, ws, 4'h1});
		n = 0;
		do begin
			bus(1'b1, 4'h2, 32'h0);
			n++;
		end while (q[0] !== 1'b0 && n < 40);
		if (q[0] !== 1'b0) begin
			errTotal++;
			endOfTest;
		end
		chk("ctrl", {23'h0, cyc, 1'b0}, {23'h0, q[15:8], q[1]});
		bus(1'b1, 4'h4, 32'h0);
		program_status_word = q;
	endtask
	function logic cond(input logic [3:0] c, input logic [7:0] p);
		logic r;
		case (c[2:0])
			3'h0: r = p[2];
			3'h1: r = p[3];
			3'h2: r = p[0];
			3'h3: r = p[3] | p[0];
			3'h4: r = p[1];
			3'h5: r = c[3] ? p[4] : 1'b1;
			3'h6: r = p[1] ^ p[2];
			default: r = (p[1] ^ p[2]) | p[0];
		endcase
		return (c[2:0] == 3'h5) ? r : r ^ c[3];
	endfunction
	initial begin
		errTotal = 0;
		checked = 0;
		reset = 1'b1;
		repeat (16) @(posedge sysClk);
		reset <= 1'b0;
		bus(1'b1, 4'h3, 32'h0);
		chk("pc", 32'h0, q);
		bus(1'b1, 4'h4, 32'h0);
		chk("psw", 32'h20, q);
		bus(1'b0, 4'hf, 32'hffffffff);
		bus(1'b1, 4'hf, 32'h0);
		chk("unmapped", 32'h0, q);
		gset(5'h0, 32'hffffffff);
		gchk(5'h0, 32'h0);
		$display("test reset done");
		gset(5'h1, 32'hf);
		run(32'h000f16a1, 32'h0, 4'h0, 8'h1);
		gchk(5'h2, 32'h0);
		chk("psw", 32'h21, program_status_word);
		run(32'hffff1681, 32'h0, 4'h0, 8'h1);
		gchk(5'h2, 32'hffff);
		chk("psw", 32'h20, program_status_word);
		gset(5'h2, 32'h80000008);
		run(32'h000012a4, 32'h0, 4'h0, 8'h1);
		gchk(5'h2, 32'hf8000000);
		chk("psw", 32'h2a, program_status_word);
		$display("test logic done");
		for (int c = 0; c < 16; c++) begin
			run({16'h0, 16'h1fe0 | c[15:0]}, 32'h0, 4'h0, 8'h1);
			gchk(5'h3, {31'h0, cond(c[3:0], 8'h2a)});
		end
		chk("psw", 32'h2a, program_status_word);
		run(32'h020017e2, 32'h0, 4'h0, 8'h1);
		run(32'h020017e5, 32'h0, 4'h0, 8'h1);
		gchk(5'h2, 32'he0000001);
		chk("psw", 32'h2a, program_status_word);
		$display("test cond done");
		gset(5'h4, 32'h120);
		run(32'h002007e4, 32'h0, 4'h0, 8'h1);
		run(32'h00200fe1, 32'h0, 4'h0, 8'h1);
		run(32'h00402fe0, 32'h0, 4'h0, 8'h1);
		gchk(5'h5, 32'h120);
		run(32'h014007e0, 32'h0, 4'h0, 8'h3);
		chk("psw", 32'hf, program_status_word);
		bus(1'b1, 4'h3, 32'h0);
		chk("pc", 32'h120, q);
		$display("test sysreg done");
		gset(5'h6, 32'h0);
		bus(1'b0, 4'h7, 32'h0);
		bus(1'b0, 4'h8, 32'h0);
		for (int i = 0; i < 4; i++) begin
			run({16'h0, bitOp[i]}, 32'h0, i[3:0], 8'h3 + i[7:0]);
			bus(1'b1, 4'h8, 32'h0);
			chk("mem", {28'h0, bitExp[i] & 4'h4}, q);
			chk("zflag", {31'h0, bitExp[i][0]}, {31'h0, program_status_word[0]});
		end
		$display("test bit done");
		for (int i = 0; i < 4; i++) begin
			gset(5'h7, 32'h123480f0);
			run({16'h0, 16'h0087 + 16'h0020 * i[15:0]}, 32'h0, 4'h0, 8'h1);
			gchk(5'h7, extExp[i]);
		end
		$display("test extend done");
		gset(5'h3, 32'h40);
		gset(5'h14, 32'haabbccdd);
		run(32'h00010785, 32'h0, 4'h0, 8'h2);
		gchk(5'h3, 32'h3a);
		bus(1'b0, 4'h7, 32'hf);
		bus(1'b1, 4'h8, 32'h0);
		chk("mem", 32'haabbccdd, q);
		run(32'h00010782, 32'h0, 4'h0, 8'h2);
		gchk(5'h3, 32'h39);
		run(32'h001b0785, 32'h12345678, 4'h1, 8'h5);
		gchk(5'h1e, 32'h12345678);
		gchk(5'h3, 32'h33);
		run(32'h000b0780, 32'h8000, 4'h0, 8'h3);
		gchk(5'h1e, 32'hffff8000);
		$display("test frame done");
		gset(5'h8, 32'h7ffffffc);
		run(32'h00004227, 32'h0, 4'h0, 8'h1);
		gchk(5'h8, 32'h7fffffff);
		chk("psw", 32'h14, program_status_word & 32'h1f);
		run(32'h00000585, 32'h0, 4'h0, 8'h3);
		run(32'h00000585, 32'h0, 4'h0, 8'h2);
		bus(1'b0, 4'h3, 32'h10);
		bus(1'b0, 4'h7, 32'h5);
		bus(1'b0, 4'h8, 32'hfffe);
		gset(5'h9, 32'h1);
		run(32'h00000049, 32'h0, 4'h0, 8'h5);
		bus(1'b1, 4'h3, 32'h0);
		chk("pc", 32'he, q);
		run(32'h00155720, 32'h0, 4'h1, 8'h3);
		gchk(5'ha, 32'hfffe);
		run(32'h00005c0a, 32'h0, 4'h0, 8'h1);
		gchk(5'hb, 32'hfffffffe);
		run(32'h010007f5, 32'h0, 4'h0, 8'h3);
		chk("psw", 32'h60, program_status_word & 32'h60);
		bus(1'b1, 4'h3, 32'h0);
		chk("pc", 32'h50, q);
		run(32'h00402fe4, 32'h0, 4'h0, 8'h1);
		gchk(5'h5, 32'h55);
		$display("test flow done");
		endOfTest;
	end
endmodule
